// [src/gg_gauge_core.sv]
// gas gauge digital core: charge counting, converter sequencing, alert pin
// assumes converter handshake on mclk and integrator events on int_clk
`timescale 1ns/10ps
`default_nettype none
module gg_gauge_core #(
  parameter int SCAN_CYCLES = gg_pkg::SCAN_CYCLES,
  parameter int PRESC_W     = 12
) (
  // core clock and synchronous reset
  input  wire  logic        mclk,
  input  wire  logic        rst,
  // integrator link
  input  wire  logic        int_clk,
  input  wire  logic        int_event,
  input  wire  logic        int_charge,
  // control register
  input  wire  logic        ctrl_wr,
  input  wire  logic [7:0]  ctrl_wdata,
  output logic       [7:0]  ctrl_rdata,
  // accumulated charge count
  input  wire  logic        acr_wr,
  input  wire  logic [15:0] acr_wdata,
  output logic       [7:0]  acr_msb,
  output logic       [7:0]  acr_lsb,
  // thresholds and status
  input  wire  logic        thr_wr,
  input  wire  logic [2:0]  thr_idx,
  input  wire  logic [15:0] thr_wdata,
  input  wire  logic        status_rd,
  output logic       [7:0]  status,
  // conversion results
  output logic       [15:0] volt_result,
  output logic       [15:0] curr_result,
  output logic       [15:0] temp_result,
  // shared converter
  output logic              adc_start,
  output logic       [1:0]  adc_chan,
  output logic              adc_sleep,
  input  wire  logic        adc_done,
  input  wire  logic [13:0] adc_data,
  // dual-role pin
  input  wire  logic        alert_or_charge_done_pin_in,
  output logic              alert_or_charge_done_pin_out,
  output logic              alert_or_charge_done_pin_oe
);

  // ----------------------------------------------------------------
  // core registers
  // ----------------------------------------------------------------
  logic [7:0]      ctrl_reg;
  logic [7:0]      ctrl_next;
  logic [15:0]     acr_reg;
  logic [15:0]     acr_next;
  logic [7:0]      status_reg;
  logic [7:0]      status_next;
  logic [15:0]     thr_reg [8];
  logic [15:0]     volt_reg;
  logic [15:0]     curr_reg;
  logic [15:0]     temp_reg;
  logic [31:0]     scan_cnt_reg;
  logic [31:0]     scan_cnt_next;
  logic            pin_meta_reg;
  logic            pin_sync_reg;
  gg_pkg::gg_seq_e seq_reg;
  gg_pkg::gg_seq_e seq_next;

  // ----------------------------------------------------------------
  // control decode
  // ----------------------------------------------------------------
  wire [1:0] mode      = ctrl_reg[gg_pkg::MODE_LSB +: 2];
  wire [1:0] role      = ctrl_reg[gg_pkg::ROLE_LSB +: 2];
  wire [1:0] wr_mode   = ctrl_wdata[gg_pkg::MODE_LSB +: 2];
  wire       role_alert = (role == gg_pkg::ROLE_ALERT);
  wire       role_cc    = (role == gg_pkg::ROLE_CHARGE);

  // ----------------------------------------------------------------
  // charge steps from the link domain
  // ----------------------------------------------------------------
  logic step_up;
  logic step_dn;
  logic up_tog_reg;
  logic dn_tog_reg;

  gg_pulse_sync u_sync_up (
    .dst_clk   (mclk),
    .dst_rst   (rst),
    .src_tog   (up_tog_reg),
    .dst_pulse (step_up)
  );

  gg_pulse_sync u_sync_dn (
    .dst_clk   (mclk),
    .dst_rst   (rst),
    .src_tog   (dn_tog_reg),
    .dst_pulse (step_dn)
  );

  // ----------------------------------------------------------------
  // accumulated charge count
  // ----------------------------------------------------------------
  wire        go_up     = step_up & ~step_dn;
  wire        go_dn     = step_dn & ~step_up;
  wire [15:0] acr_step  = go_up ? acr_reg + 16'h0001 : acr_reg - 16'h0001;
  wire        acr_wrap  = (go_up && acr_reg == 16'hFFFF) || (go_dn && acr_reg == 16'h0000);
  wire        cc_load   = role_cc & ~pin_sync_reg;
  wire        stepping  = (go_up | go_dn) & ~acr_wr & ~cc_load;
  wire        chg_high  = stepping && (acr_step > thr_reg[0]);
  wire        chg_low   = stepping && (acr_step < thr_reg[1]);

  // priority: host write, then charge-done preset, then step
  always_comb
  begin
    acr_next = acr_reg;
    if (acr_wr)
      acr_next = acr_wdata;
    else if (cc_load)
      acr_next = gg_pkg::ACR_FULL;
    else if (go_up | go_dn)
      acr_next = acr_step;
  end

  // count exposed as two bytes of one value
  assign acr_msb = acr_reg[15:8];
  assign acr_lsb = acr_reg[7:0];

  // ----------------------------------------------------------------
  // conversion sequencer
  // ----------------------------------------------------------------
  wire scan_tick = (scan_cnt_reg == 32'(SCAN_CYCLES - 1));
  wire wr_start  = ctrl_wr && (wr_mode != gg_pkg::MODE_SLEEP);
  wire set_req   = wr_start || (mode == gg_pkg::MODE_SCAN && scan_tick) || (mode == gg_pkg::MODE_AUTO);
  wire set_end   = (seq_reg == gg_pkg::GG_TEMP) && adc_done;

  // voltage, current, temperature, then sleep
  always_comb
  begin
    seq_next = seq_reg;
    case (seq_reg)
      gg_pkg::GG_IDLE: if (set_req) seq_next = gg_pkg::GG_VOLT;
      gg_pkg::GG_VOLT: if (adc_done) seq_next = gg_pkg::GG_CURR;
      gg_pkg::GG_CURR: if (adc_done) seq_next = gg_pkg::GG_TEMP;
      gg_pkg::GG_TEMP: if (adc_done) seq_next = gg_pkg::GG_IDLE;
      default:         seq_next = gg_pkg::GG_IDLE;
    endcase
  end

  // scan interval timer, restarted by any control write
  always_comb
  begin
    scan_cnt_next = scan_cnt_reg + 32'h0000_0001;
    if (ctrl_wr || mode != gg_pkg::MODE_SCAN || scan_tick)
      scan_cnt_next = 32'h0000_0000;
  end

  // control: host write wins; manual mode falls back to sleep after its set
  always_comb
  begin
    ctrl_next = ctrl_reg;
    if (ctrl_wr)
      ctrl_next = ctrl_wdata;
    else if (set_end && mode == gg_pkg::MODE_MANUAL)
      ctrl_next[gg_pkg::MODE_LSB +: 2] = gg_pkg::MODE_SLEEP;
  end

  assign adc_start = (seq_reg != gg_pkg::GG_IDLE);
  assign adc_sleep = (seq_reg == gg_pkg::GG_IDLE);
  assign adc_chan  = (seq_reg == gg_pkg::GG_CURR) ? gg_pkg::CHAN_CURR :
                     (seq_reg == gg_pkg::GG_TEMP) ? gg_pkg::CHAN_TEMP : gg_pkg::CHAN_VOLT;

  // ----------------------------------------------------------------
  // result placement and threshold checks
  // ----------------------------------------------------------------
  localparam int VPAD = 16 - gg_pkg::VOLT_BITS;
  localparam int IPAD = 16 - gg_pkg::CURR_BITS;
  localparam int TPAD = 16 - gg_pkg::TEMP_BITS;

  wire [15:0] volt_val = {adc_data[gg_pkg::VOLT_BITS-1:0], {VPAD{1'b0}}};
  wire [15:0] curr_val = {adc_data[gg_pkg::CURR_BITS-1:0], {IPAD{1'b0}}};
  wire [15:0] temp_val = {adc_data[gg_pkg::TEMP_BITS-1:0], {TPAD{1'b0}}};
  wire v_done = adc_done && seq_reg == gg_pkg::GG_VOLT;
  wire i_done = adc_done && seq_reg == gg_pkg::GG_CURR;
  wire t_done = adc_done && seq_reg == gg_pkg::GG_TEMP;
  wire v_alert = v_done && (volt_val > thr_reg[2] || volt_val < thr_reg[3]);
  wire i_alert = i_done && (curr_val > thr_reg[4] || curr_val < thr_reg[5]);
  wire t_alert = t_done && (temp_val[15:8] > thr_reg[6][7:0] || temp_val[15:8] < thr_reg[7][7:0]);

  // ----------------------------------------------------------------
  // status flags: a new event wins over the read clear
  // ----------------------------------------------------------------
  wire [7:0] status_set = {1'b0, i_alert, acr_wrap & stepping, t_alert, chg_high, chg_low, v_alert, 1'b0};
  assign status_next = (status_reg & {8{~status_rd}}) | status_set;
  assign status      = status_reg;
  assign ctrl_rdata  = ctrl_reg;
  assign volt_result = volt_reg;
  assign curr_result = curr_reg;
  assign temp_result = temp_reg;

  // ----------------------------------------------------------------
  // dual-role pin: in alert role, open drain low while any of status bits 1 to 6 stands
  // ----------------------------------------------------------------
  assign alert_or_charge_done_pin_out = 1'b0;
  assign alert_or_charge_done_pin_oe  = role_alert && (|status_reg[gg_pkg::ST_CURR:gg_pkg::ST_VOLT]);

  // ----------------------------------------------------------------
  // core register updates
  // ----------------------------------------------------------------
  // control, count, status, sequencer
  always_ff @(posedge mclk)
  begin
    if (rst)
    begin
      ctrl_reg     <= gg_pkg::CTRL_RST;
      acr_reg      <= gg_pkg::ACR_RST;
      status_reg   <= gg_pkg::STATUS_RST;
      seq_reg      <= gg_pkg::GG_IDLE;
      scan_cnt_reg <= 32'h0000_0000;
    end
    else
    begin
      ctrl_reg     <= ctrl_next;
      acr_reg      <= acr_next;
      status_reg   <= status_next;
      seq_reg      <= seq_next;
      scan_cnt_reg <= scan_cnt_next;
    end
  end

  // results, updated at the end of their own conversion
  always_ff @(posedge mclk)
  begin
    if (rst)
    begin
      volt_reg <= 16'h0000;
      curr_reg <= 16'h0000;
      temp_reg <= 16'h0000;
    end
    else
    begin
      if (v_done) volt_reg <= volt_val;
      if (i_done) curr_reg <= curr_val;
      if (t_done) temp_reg <= temp_val;
    end
  end

  // pin input synchroniser
  always_ff @(posedge mclk)
  begin
    if (rst)
    begin
      pin_meta_reg <= 1'b1;
      pin_sync_reg <= 1'b1;
    end
    else
    begin
      pin_meta_reg <= alert_or_charge_done_pin_in;
      pin_sync_reg <= pin_meta_reg;
    end
  end

  // threshold registers, high ones reset to all ones and low ones to zero
  genvar gi;
  generate
    for (gi = 0; gi < 8; gi++)
    begin : g_thr
      always_ff @(posedge mclk)
      begin
        if (rst)
          thr_reg[gi] <= (gi % 2 == 0) ? gg_pkg::THR_HI_RST : gg_pkg::THR_LO_RST;
        else if (thr_wr && thr_idx == 3'(gi))
          thr_reg[gi] <= thr_wdata;
      end
    end
  endgenerate

  // ----------------------------------------------------------------
  // link domain: reset and prescaler code crossing, prescaler
  // ----------------------------------------------------------------
  logic               lrst_meta_reg;
  logic               lrst_reg;
  logic [2:0]         code_meta_reg;
  logic [2:0]         code_sync_reg;
  logic [2:0]         code_hold_reg;
  logic [2:0]         code_reg;
  logic [PRESC_W-1:0] presc_reg;
  logic [PRESC_W-1:0] presc_next;

  // factor is four to the code, capped at 4096
  wire [PRESC_W-1:0] presc_top = (code_reg >= gg_pkg::PRESC_CAP_CODE) ? {PRESC_W{1'b1}} :
                                 PRESC_W'((13'h0001 << {code_reg, 1'b0}) - 13'h0001);
  wire presc_ovf = int_event && int_charge && (presc_reg == presc_top);
  wire presc_unf = int_event && !int_charge && (presc_reg == {PRESC_W{1'b0}});

  // count events up on charge, down on discharge, wrap at the factor
  always_comb
  begin
    presc_next = presc_reg;
    if (presc_ovf)
      presc_next = {PRESC_W{1'b0}};
    else if (presc_unf)
      presc_next = presc_top;
    else if (int_event)
      presc_next = int_charge ? presc_reg + 1'b1 : presc_reg - 1'b1;
  end

  // link reset and code synchronisers; code taken only when two samples agree
  always_ff @(posedge int_clk)
  begin
    lrst_meta_reg <= rst;
    lrst_reg      <= lrst_meta_reg;
    code_meta_reg <= ctrl_reg[gg_pkg::PRESC_LSB +: 3];
    code_sync_reg <= code_meta_reg;
    code_hold_reg <= code_sync_reg;
    if (code_sync_reg == code_hold_reg) code_reg <= code_hold_reg; // no torn multi-bit code
  end

  // prescaler and step toggles
  always_ff @(posedge int_clk)
  begin
    if (lrst_reg)
    begin
      presc_reg  <= {PRESC_W{1'b0}};
      up_tog_reg <= 1'b0;
      dn_tog_reg <= 1'b0;
    end
    else
    begin
      presc_reg  <= presc_next;
      up_tog_reg <= up_tog_reg ^ presc_ovf;
      dn_tog_reg <= dn_tog_reg ^ presc_unf;
    end
  end

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  sequence set_last_s;
    seq_reg == gg_pkg::GG_TEMP && adc_done;
  endsequence

  sequence sleep_after_s;
    adc_sleep && temp_reg == $past(temp_val);
  endsequence

  reset_vals_a: assert property (@(posedge mclk) $fell(rst) |-> ctrl_reg == 8'h3C && acr_reg == 16'h7FFF
    && thr_reg[0] == 16'hFFFF && thr_reg[1] == 16'h0000 && adc_sleep) else $error("reset values wrong");
  alert_pull_a: assert property (@(posedge mclk) disable iff (rst)
    $rose(status_reg[gg_pkg::ST_VOLT]) && role_alert |-> alert_or_charge_done_pin_oe)
    else $error("alert pin not pulled");
  cc_preset_a: assert property (@(posedge mclk) disable iff (rst)
    role_cc && !pin_sync_reg && !acr_wr |=> acr_reg == 16'hFFFF) else $error("charge done preset missed");
  step_one_a: assert property (@(posedge mclk) disable iff (rst)
    go_up && !acr_wr && !cc_load |=> acr_reg == $past(acr_reg) + 16'h0001) else $error("step not one count");
  wrap_flag_a: assert property (@(posedge mclk) disable iff (rst)
    go_dn && acr_reg == 16'h0000 && !acr_wr && !cc_load |=> acr_reg == 16'hFFFF && status_reg[5])
    else $error("underflow not flagged");
  seq_order_a: assert property (@(posedge mclk) disable iff (rst)
    seq_reg == gg_pkg::GG_VOLT && adc_done |=> seq_reg == gg_pkg::GG_CURR && adc_chan == 2'h1)
    else $error("voltage not followed by current");
  set_sleep_a: assert property (@(posedge mclk) disable iff (rst)
    set_last_s |=> sleep_after_s) else $error("converter not asleep after set");
  volt_place_a: assert property (@(posedge mclk) disable iff (rst)
    v_done |=> volt_reg == {$past(adc_data[13:0]), 2'b00}) else $error("voltage result misplaced");
  scan_start_a: assert property (@(posedge mclk) disable iff (rst)
    mode == 2'h2 && scan_tick && adc_sleep && !ctrl_wr |=> seq_reg == gg_pkg::GG_VOLT)
    else $error("scan interval did not start set");
  read_clear_a: assert property (@(posedge mclk) disable iff (rst)
    status_rd && status_set == 8'h00 |=> status_reg == 8'h00) else $error("status not cleared");
  presc_wrap_a: assert property (@(posedge int_clk) disable iff (lrst_reg)
    presc_ovf |=> presc_reg == 12'h000 && up_tog_reg != $past(up_tog_reg)) else $error("prescaler wrap wrong");

endmodule
`default_nettype wire

// [src/gg_pkg.sv]
// gas gauge constants: control field layout, reset values, codes and timing
// assumes a 40 MHz core clock and a separate integrator clock on the link side
package gg_pkg;

  // ----------------------------------------------------------------
  // control register layout and reset value
  // ----------------------------------------------------------------
  localparam logic [7:0] CTRL_RST   = 8'h3C;
  localparam int         MODE_LSB   = 6;
  localparam int         PRESC_LSB  = 3;
  localparam int         ROLE_LSB   = 1;

  localparam logic [1:0] MODE_SLEEP  = 2'h0;
  localparam logic [1:0] MODE_MANUAL = 2'h1;
  localparam logic [1:0] MODE_SCAN   = 2'h2;
  localparam logic [1:0] MODE_AUTO   = 2'h3;

  localparam logic [1:0] ROLE_CHARGE = 2'h1;
  localparam logic [1:0] ROLE_ALERT  = 2'h2;

  // ----------------------------------------------------------------
  // status bits and data reset values
  // ----------------------------------------------------------------
  localparam logic [7:0]  STATUS_RST = 8'h01;
  localparam int          ST_UVLO    = 0;
  localparam int          ST_VOLT    = 1;
  localparam int          ST_CLOW    = 2;
  localparam int          ST_CHIGH   = 3;
  localparam int          ST_TEMP    = 4;
  localparam int          ST_OVF     = 5;
  localparam int          ST_CURR    = 6;
  localparam logic [15:0] ACR_RST    = 16'h7FFF;
  localparam logic [15:0] ACR_FULL   = 16'hFFFF;
  localparam logic [15:0] THR_HI_RST = 16'hFFFF;
  localparam logic [15:0] THR_LO_RST = 16'h0000;

  // ----------------------------------------------------------------
  // converter widths and channel codes
  // ----------------------------------------------------------------
  localparam int         VOLT_BITS = 14;
  localparam int         CURR_BITS = 12;
  localparam int         TEMP_BITS = 11;
  localparam logic [1:0] CHAN_VOLT = 2'h0;
  localparam logic [1:0] CHAN_CURR = 2'h1;
  localparam logic [1:0] CHAN_TEMP = 2'h2;

  // ----------------------------------------------------------------
  // prescaler and scan timing
  // ----------------------------------------------------------------
  localparam logic [2:0] PRESC_CAP_CODE = 3'h6;
  localparam int         MCLK_HZ        = 40000000;
  localparam int         SCAN_PERIOD_S  = 10;
  localparam int         SCAN_CYCLES    = SCAN_PERIOD_S * MCLK_HZ;

  typedef enum logic [1:0] {
    GG_IDLE = 2'b00,
    GG_VOLT = 2'b01,
    GG_CURR = 2'b11,
    GG_TEMP = 2'b10
  } gg_seq_e;

endpackage

// [src/gg_pulse_sync.sv]
// toggle to pulse crossing into a destination clock domain
// assumes the source toggles at most once per three destination cycles
`timescale 1ns/10ps
`default_nettype none
module gg_pulse_sync (
  // destination clock and reset
  input  wire  logic dst_clk,
  input  wire  logic dst_rst,
  // toggle from the source domain
  input  wire  logic src_tog,
  // one-cycle pulse per toggle
  output logic       dst_pulse
);

  logic meta_reg;
  logic sync_reg;
  logic last_reg;

  // two-stage synchroniser, then edge memory
  always_ff @(posedge dst_clk)
  begin
    if (dst_rst)
    begin
      meta_reg <= 1'b0;
      sync_reg <= 1'b0;
      last_reg <= 1'b0;
    end
    else
    begin
      meta_reg <= src_tog;
      sync_reg <= meta_reg;
      last_reg <= sync_reg;
    end
  end

  // any change of the synced toggle is one event
  assign dst_pulse = sync_reg ^ last_reg;

endmodule
`default_nettype wire

// [tb/gg_far_model.sv]
// far-side model: shared converter and integrator event source
// assumes the core's converter handshake on mclk, free-running int_clk
`timescale 1ns/10ps
`default_nettype none
module gg_far_model (
  // clocks
  input  wire  logic        mclk,
  input  wire  logic        int_clk,
  // converter side
  input  wire  logic        adc_start,
  input  wire  logic [1:0]  adc_chan,
  output logic              adc_done,
  output logic       [13:0] adc_data,
  output logic       [5:0]  chan_log,
  // integrator side
  input  wire  logic [15:0] ev_req,
  input  wire  logic        ev_up,
  output logic              int_event,
  output logic              int_charge,
  output logic       [15:0] ev_sent
);
  logic [3:0] wait_cnt;
  logic       ev_gap;

  initial
  begin
    {adc_done, adc_data, chan_log, wait_cnt} = '0;
    {int_event, int_charge, ev_sent, ev_gap} = '0;
  end

  // converter: slow on voltage, prompt otherwise; data toggles when idle
  always @(posedge mclk)
  begin
    adc_done <= 1'b0;
    adc_data <= ~adc_data;
    if (adc_start && !adc_done)
    begin
      wait_cnt <= wait_cnt + 4'h1;
      if (wait_cnt == ((adc_chan == 2'h0) ? 4'h9 : 4'h2))
      begin
        adc_done <= 1'b1;
        adc_data <= 14'h3A5C + {12'h000, adc_chan};
        chan_log <= {chan_log[3:0], adc_chan};
        wait_cnt <= 4'h0;
      end
    end
  end

  // integrator: one event every other int_clk until the target is met
  always @(posedge int_clk)
  begin
    int_event <= 1'b0;
    int_charge <= ev_up;
    ev_gap <= ~ev_gap;
    if (ev_gap && ev_sent != ev_req)
    begin
      int_event <= 1'b1;
      ev_sent <= ev_sent + 16'h0001;
    end
  end
endmodule
`default_nettype wire

// [tb/gg_gauge_core_tb.sv]
// testbench for the gauge core: table of count writes, then hand cases
// assumes the far-side model drives converter and integrator link
`timescale 1ns/10ps
`default_nettype none
module gg_gauge_core_tb;
  localparam int SCAN = 200;
  logic mclk = 1'b0, int_clk = 1'b0, rst = 1'b1, chg_n = 1'b1, ev_up = 1'b0;
  logic ctrl_wr = 1'b0, acr_wr = 1'b0, thr_wr = 1'b0, status_rd = 1'b0;
  logic [7:0] ctrl_wdata = 8'h00, ctrl_rdata, acr_msb, acr_lsb, status;
  logic [15:0] acr_wdata = 16'h0000, thr_wdata = 16'h0000, ev_req = 16'h0000, ev_sent;
  logic [15:0] volt_result, curr_result, temp_result;
  logic [2:0] thr_idx = 3'h0;
  logic [1:0] adc_chan;
  logic [13:0] adc_data;
  logic [5:0] chan_log;
  logic adc_start, adc_sleep, adc_done, pin_out, pin_oe, int_event, int_charge;
  wire logic pin_wire;
  int n_mismatch = 0, cmp_count = 0, t;
  logic seen;
  logic [31:0] rows [4] = '{32'h1234_1234, 32'h0000_0000, 32'hFFFF_FFFF, 32'h8001_8001};

  // clocks and pin: pull-up, core pulls low, charger pulls low
  always #12.5 mclk = ~mclk;
  always #24 int_clk = ~int_clk;
  assign pin_wire = (pin_oe ? pin_out : 1'b1) & chg_n;

  gg_gauge_core #(.SCAN_CYCLES(SCAN)) dut (.mclk(mclk), .rst(rst), .int_clk(int_clk),
    .int_event(int_event), .int_charge(int_charge), .ctrl_wr(ctrl_wr), .ctrl_wdata(ctrl_wdata),
    .ctrl_rdata(ctrl_rdata), .acr_wr(acr_wr), .acr_wdata(acr_wdata), .acr_msb(acr_msb),
    .acr_lsb(acr_lsb), .thr_wr(thr_wr), .thr_idx(thr_idx), .thr_wdata(thr_wdata),
    .status_rd(status_rd), .status(status), .volt_result(volt_result), .curr_result(curr_result),
    .temp_result(temp_result), .adc_start(adc_start), .adc_chan(adc_chan), .adc_sleep(adc_sleep),
    .adc_done(adc_done), .adc_data(adc_data), .alert_or_charge_done_pin_in(pin_wire),
    .alert_or_charge_done_pin_out(pin_out), .alert_or_charge_done_pin_oe(pin_oe));

  gg_far_model far (.mclk(mclk), .int_clk(int_clk), .adc_start(adc_start), .adc_chan(adc_chan),
    .adc_done(adc_done), .adc_data(adc_data), .chan_log(chan_log), .ev_req(ev_req),
    .ev_up(ev_up), .int_event(int_event), .int_charge(int_charge), .ev_sent(ev_sent));

  // ------------------------------------------------------------
  // shared tasks
  // ------------------------------------------------------------
  task automatic results;
    $display("comparisons %0d mismatches %0d", cmp_count, n_mismatch);
    if (n_mismatch == 0 && cmp_count > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask

  task automatic chk(input string nm, input logic [15:0] exp, input logic [15:0] got);
    cmp_count++;
    if (got !== exp)
    begin
      n_mismatch++;
      $display("MISMATCH %s expected %h seen %h", nm, exp, got);
    end
  endtask

  // one strobe: 0 control, 1 count, 2 threshold, 3 status read
  task automatic wr(input int k, input logic [15:0] d, input logic [2:0] i);
    @(posedge mclk);
    {ctrl_wr, acr_wr, thr_wr, status_rd} <= 4'(8 >> k);
    ctrl_wdata <= d[7:0];
    acr_wdata <= d;
    thr_wdata <= d;
    thr_idx <= i;
    @(posedge mclk);
    {ctrl_wr, acr_wr, thr_wr, status_rd} <= 4'h0;
    #1;
  endtask

  task automatic bound(input int n, input int lim);
    if (n >= lim)
    begin
      n_mismatch++;
      $display("MISMATCH wait expected done seen timeout");
      results();
    end
  endtask

  task automatic wait_idle;
    int n;
    n = 0;
    repeat (2) @(posedge mclk);
    #1;
    for (n = 0; adc_sleep !== 1'b1 && n < 500; n++)
      @(posedge mclk);
    bound(n, 500);
    #1;
  endtask

  task automatic events(input logic up, input int num);
    int n;
    @(posedge mclk);
    ev_up <= up;
    repeat (12) @(posedge mclk);
    ev_req <= ev_req + 16'(num);
    repeat (2) @(posedge mclk);
    for (n = 0; ev_sent !== ev_req && n < 20000; n++)
      @(posedge mclk);
    bound(n, 20000);
    repeat (10) @(posedge mclk);
    #1;
  endtask

  // ------------------------------------------------------------
  // main sequence
  // ------------------------------------------------------------
  initial
  begin
    repeat (4) @(posedge mclk);
    rst <= 1'b0;
    foreach (rows[r])
    begin
      wr(1, rows[r][31:16], 3'h0);
      chk("count", rows[r][15:0], {acr_msb, acr_lsb});
    end
    $display("done: count table");
    wr(2, 16'h0000, 3'h2);
    wr(2, 16'h0000, 3'h4);
    wr(2, 16'h00FF, 3'h7);
    wr(3, 16'h0000, 3'h0);
    wr(0, 16'h007C, 3'h0);
    chk("start", 16'h0001, {15'h0, adc_start & ~adc_sleep});
    wait_idle();
    chk("volt", {14'h3A5C, 2'h0}, volt_result);
    chk("curr", {12'hA5D, 4'h0}, curr_result);
    chk("temp", {11'h25E, 5'h00}, temp_result);
    chk("order", 16'h0006, {10'h0, chan_log});
    chk("ctrl", 16'h003C, {8'h00, ctrl_rdata});
    chk("status", 16'h0052, {8'h00, status});
    chk("alert", 16'h0001, {15'h0, pin_oe});
    chk("alert pin", 16'h0000, {15'h0, pin_wire});
    wr(3, 16'h0000, 3'h0);
    chk("cleared", 16'h0000, {7'h00, status, pin_oe});
    $display("done: manual set");
    wr(0, 16'h0004, 3'h0);
    wr(1, 16'hFFFF, 3'h0);
    wr(2, 16'h0001, 3'h1);
    events(1'b1, 1);
    chk("wrap up", 16'h0000, {acr_msb, acr_lsb});
    chk("ovf", 16'h0024, {8'h00, status});
    wr(2, 16'hFFFD, 3'h0);
    wr(3, 16'h0000, 3'h0);
    events(1'b0, 2);
    chk("wrap down", 16'hFFFE, {acr_msb, acr_lsb});
    chk("charge hi", 16'h0028, {8'h00, status});
    chk("alert hi", 16'h0001, {15'h0, pin_oe});
    wr(0, 16'h000C, 3'h0);
    events(1'b1, 4);
    chk("presc 4", 16'hFFFF, {acr_msb, acr_lsb});
    events(1'b1, 3);
    chk("presc part", 16'hFFFF, {acr_msb, acr_lsb});
    $display("done: charge steps");
    wr(0, 16'h000A, 3'h0);
    wr(1, 16'h1234, 3'h0);
    chk("role oe", 16'h0000, {15'h0, pin_oe});
    @(posedge mclk);
    chg_n <= 1'b0;
    repeat (6) @(posedge mclk);
    chg_n <= 1'b1;
    #1;
    chk("preset", 16'hFFFF, {acr_msb, acr_lsb});
    $display("done: charge done role");
    wr(0, 16'h00BC, 3'h0);
    seen = 1'b0;
    for (t = 1; t < 1000 && !(seen && adc_start === 1'b1); t++)
    begin
      @(posedge mclk);
      #1;
      seen = seen | (adc_sleep === 1'b1);
    end
    cmp_count++;
    if (t < SCAN - 3 || t > SCAN + 3)
    begin
      n_mismatch++;
      $display("MISMATCH scan gap expected %0d seen %0d", SCAN, t);
    end
    wr(0, 16'h003C, 3'h0);
    wait_idle();
    $display("done: scan");
    wr(0, 16'h00FC, 3'h0);
    wait_idle();
    chk("auto", 16'h0001, {15'h0, adc_start});
    wr(0, 16'h003C, 3'h0);
    wait_idle();
    $display("done: auto");
    @(posedge mclk);
    rst <= 1'b1;
    repeat (8) @(posedge mclk);
    rst <= 1'b0;
    #1;
    chk("rst ctrl", 16'h003C, {8'h00, ctrl_rdata});
    chk("rst count", 16'h7FFF, {acr_msb, acr_lsb});
    chk("rst status", 16'h0001, {8'h00, status});
    chk("rst adc", 16'h0002, {14'h0, adc_sleep, adc_start});
    chk("rst res", 16'h0000, volt_result | curr_result | temp_result);
    chk("rst oe", 16'h0000, {15'h0, pin_oe});
    events(1'b1, 4096);
    chk("rst presc", 16'h8000, {acr_msb, acr_lsb});
    $display("done: reset");
    results();
  end
endmodule
`default_nettype wire
